// ### verilog/rvs_defines.svh
// Register offsets, field positions, reset values and delay counts
`ifndef RVS_DEFINES_SVH
`define RVS_DEFINES_SVH

`define RVS_ADDR_W 6
`define RVS_OFF_STATUS 6'h3F
`define RVS_OFF_STACK 6'h3D
`define RVS_OFF_CAUSE 6'h34
`define RVS_OFF_EN_LO 6'h36
`define RVS_OFF_EN_HI 6'h37
`define RVS_OFF_PEND_LO 6'h20
`define RVS_OFF_PEND_HI 6'h22

`define RVS_GIE_BIT 7
`define RVS_CAUSE_WDT 3
`define RVS_CAUSE_BOD 2
`define RVS_CAUSE_EXT 1
`define RVS_CAUSE_POR 0

`define RVS_STACK_RST 8'h00
`define RVS_NUM_IRQ 13
`define RVS_VEC_W 12
`define RVS_VEC_RESET 12'h000
`define RVS_VEC_FIRST 12'h001

`define RVS_SEL_W 3
`define RVS_CNT_W 17
`define RVS_RT_SHORT 17'h01000
`define RVS_RT_LONG 17'h10000
`define RVS_CK_SHORT 17'h00006
`define RVS_CK_1K 17'h00400
`define RVS_CK_16K 17'h04000

`endif

// ### verilog/rvs_pkg.sv
// Types shared by the reset, vector and stack control block
package rvs_pkg;

   typedef enum logic [5:0] {
      RVS_ST_HOLD  = 6'b000001,
      RVS_ST_RT    = 6'b000010,
      RVS_ST_CK    = 6'b000100,
      RVS_ST_RUN   = 6'b001000,
      RVS_ST_SLEEP = 6'b010000,
      RVS_ST_WAKE  = 6'b100000
   } rvs_state_t;

   typedef struct packed {
      logic push_byte;
      logic pop_byte;
      logic call_push;
      logic sub_exit;
      logic irq_exit;
   } rvs_stack_op_t;

   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rvs_bus_req_t;

endpackage : rvs_pkg

// ### verilog/rvs_reset_vector_ctrl.sv
// Reset sequencing, interrupt vectoring and stack pointer control
//
// Operation
// RL1: stack_top_pointer is one 8-bit register at I/O address 3D.
// RL2: A byte push lowers the stack pointer by one.
// RL3: A call or interrupt entry lowers the stack pointer by two.
// RL4: A byte pop raises the stack pointer by one.
// RL5: Subroutine or interrupt exit raises the stack pointer by two.
// RL6: Software loads the stack pointer above 60 before calls or interrupts.
// RL7: Thirteen interrupt sources plus reset each own a vector.
// RL8: An interrupt is taken only with its enable and global enable set.
// RL9: Lowest vector address wins; reset outranks everything.
// RL10: Vectors 000 reset through 006 timer0 wrap.
// RL11: Vectors 007 serial transfer through 00D comparator.
// RL12: Any reset restores registers and starts fetch at address 000.
// RL13: Pin, power-on, brown-out and watchdog resets share one vector.
// RL14: Watchdog reset only when watchdog enabled and its period expired.
// RL15: Selector 000 to 011 give 4ms+6, 6, 64ms+16K, 4ms+16K clocks.
// RL16: Selector 100 to 111 give 16K, 64ms+1K, 4ms+1K, 1K clocks.
// RL17: Wake from sleep counts only the main clock portion.
// RL18: Millisecond portion is timed on watchdog oscillator cycles.
// RL19: Short delay is 4K, long delay 64K watchdog oscillator cycles.
// RL20: Watchdog reset is one clock long; delay starts as it ends.
// RL21: Cause flags record watchdog, brown-out, external and power-on resets.
// RL22: Vectoring clears global enable and the serviced request flag.
// RL23: Core held in reset while any source active, then full delay.
// RL24: Arbitration at instruction boundaries gives one winning vector.
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`include "rvs_defines.svh"

module rvs_reset_vector_ctrl
   import rvs_pkg::*;
#(
   parameter logic [16:0] P_RT_LONG = `RVS_RT_LONG,
   parameter logic [16:0] P_CK_16K = `RVS_CK_16K
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Reset detectors and watchdog
   input wire logic por_req,
   input wire logic ext_reset_req,
   input wire logic bod_req,
   input wire logic wdt_enable,
   input wire logic wdt_timeout,
   input wire logic wdt_osc_tick,
   input wire logic [2:0] startup_delay_select,
   // Core handshake
   input wire logic sleep_req,
   input wire logic wake_req,
   input wire logic instr_boundary,
   input wire rvs_stack_op_t stack_op,
   // Peripheral interrupt requests, one-cycle pulses
   input wire logic [12:0] irq_pulse,
   // Register port
   input wire rvs_bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   // Core outputs
   output logic core_reset,
   output logic core_halt,
   output logic irq_take,
   output logic [11:0] irq_vector,
   output logic [7:0] stack_top_pointer
);

   rvs_state_t state_reg;
   rvs_state_t state_next;
   logic [16:0] cnt_reg;
   logic [16:0] cnt_next;
   logic wdt_pulse_reg;
   logic src_active;
   logic in_reset;
   logic [7:0] stk_reg;
   logic gie_reg;
   logic [12:0] irq_en_reg;
   logic [12:0] pend_reg;
   logic [3:0] cause_reg;
   logic [7:0] rdata_reg;
   logic core_reset_reg;
   logic core_halt_reg;
   logic take_reg;
   logic [11:0] vector_reg;
   logic take_now;
   logic [12:0] live;
   logic [3:0] win_idx;
   logic wr_stack;
   logic wr_status;

   // Real-time part in watchdog oscillator cycles
   function automatic logic [16:0] rt_cycles(input logic [2:0] sel);
      unique case (sel)
         3'h0, 3'h3, 3'h6: rt_cycles = `RVS_RT_SHORT; // RL15 RL16 RL19
         3'h2, 3'h5: rt_cycles = P_RT_LONG; // RL15 RL16 RL19
         default: rt_cycles = 17'h00000;
      endcase
   endfunction : rt_cycles
   // Main clock part in clock cycles
   function automatic logic [16:0] ck_cycles(input logic [2:0] sel);
      unique case (sel)
         3'h0, 3'h1: ck_cycles = `RVS_CK_SHORT; // RL15
         3'h2, 3'h3, 3'h4: ck_cycles = P_CK_16K; // RL15 RL16
         default: ck_cycles = `RVS_CK_1K; // RL16
      endcase
   endfunction : ck_cycles
   // Index of the lowest set request
   function automatic logic [3:0] lowest(input logic [12:0] req);
      lowest = 4'h0;
      for (int i = 12; i >= 0; i--) begin
         if (req[i]) begin
            lowest = 4'(i);
         end
      end
   endfunction : lowest

   assign src_active = por_req | ext_reset_req | bod_req | wdt_pulse_reg;
   assign in_reset = (state_reg == RVS_ST_HOLD);
   assign live = pend_reg & irq_en_reg;
   assign win_idx = lowest(live);
   assign take_now = (state_reg == RVS_ST_RUN) && instr_boundary && gie_reg
      && (|live) && !src_active; // RL8 RL24
   assign wr_stack = bus_req.wr && (bus_req.addr == `RVS_OFF_STACK);
   assign wr_status = bus_req.wr && (bus_req.addr == `RVS_OFF_STATUS);
   // One clock watchdog reset pulse
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wdt_pulse_reg <= 1'b0;
      end else begin
         wdt_pulse_reg <= wdt_enable && wdt_timeout && !wdt_pulse_reg; // RL14 RL20
      end
   end
   // Start-up sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      if (src_active) begin
         state_next = RVS_ST_HOLD; // RL23
      end else begin
         unique case (state_reg)
            RVS_ST_HOLD: begin
               if (rt_cycles(startup_delay_select) != 17'h00000) begin
                  state_next = RVS_ST_RT;
                  cnt_next = rt_cycles(startup_delay_select);
               end else begin
                  state_next = RVS_ST_CK;
                  cnt_next = ck_cycles(startup_delay_select);
               end
            end
            RVS_ST_RT: begin
               if (wdt_osc_tick) begin // RL18
                  if (cnt_reg == 17'h00001) begin
                     state_next = RVS_ST_CK;
                     cnt_next = ck_cycles(startup_delay_select);
                  end else begin
                     cnt_next = cnt_reg - 17'h00001;
                  end
               end
            end
            RVS_ST_CK, RVS_ST_WAKE: begin
               if (cnt_reg == 17'h00001) begin
                  state_next = RVS_ST_RUN; // RL23
               end else begin
                  cnt_next = cnt_reg - 17'h00001;
               end
            end
            RVS_ST_RUN: begin
               if (sleep_req) begin
                  state_next = RVS_ST_SLEEP;
               end
            end
            RVS_ST_SLEEP: begin
               if (wake_req) begin
                  state_next = RVS_ST_WAKE; // RL17
                  cnt_next = ck_cycles(startup_delay_select);
               end
            end
         endcase
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= RVS_ST_HOLD;
         cnt_reg <= 17'h00000;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end
   // Core control outputs
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         core_reset_reg <= 1'b1;
         core_halt_reg <= 1'b0;
      end else begin
         core_reset_reg <= (state_next == RVS_ST_HOLD)
            || (state_next == RVS_ST_RT) || (state_next == RVS_ST_CK); // RL23
         core_halt_reg <= (state_next == RVS_ST_SLEEP)
            || (state_next == RVS_ST_WAKE);
      end
   end
   // Reset cause flags; a new cause wins over a software clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cause_reg <= 4'h0;
      end else if (por_req) begin
         cause_reg <= 4'h1; // RL21
      end else begin
         cause_reg <= ((bus_req.wr && bus_req.addr == `RVS_OFF_CAUSE)
            ? (cause_reg & bus_req.wdata[3:0]) : cause_reg)
            | {wdt_pulse_reg, bod_req, ext_reset_req, 1'b0}; // RL21
      end
   end
   // Stack pointer
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stk_reg <= `RVS_STACK_RST;
      end else if (in_reset) begin
         stk_reg <= `RVS_STACK_RST; // RL12
      end else if (take_now || stack_op.call_push) begin
         stk_reg <= stk_reg - 8'h02; // RL3
      end else if (stack_op.push_byte) begin
         stk_reg <= stk_reg - 8'h01; // RL2
      end else if (stack_op.pop_byte) begin
         stk_reg <= stk_reg + 8'h01; // RL4
      end else if (stack_op.sub_exit || stack_op.irq_exit) begin
         stk_reg <= stk_reg + 8'h02; // RL5
      end else if (wr_stack) begin
         stk_reg <= bus_req.wdata; // RL1
      end
   end
   // Global interrupt enable
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gie_reg <= 1'b0;
      end else if (in_reset) begin
         gie_reg <= 1'b0; // RL12
      end else if (take_now) begin
         gie_reg <= 1'b0; // RL22
      end else if (stack_op.irq_exit) begin
         gie_reg <= 1'b1;
      end else if (wr_status) begin
         gie_reg <= bus_req.wdata[`RVS_GIE_BIT];
      end
   end
   // Individual enables
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_en_reg <= 13'h0000;
      end else if (in_reset) begin
         irq_en_reg <= 13'h0000; // RL12
      end else if (bus_req.wr && bus_req.addr == `RVS_OFF_EN_LO) begin
         irq_en_reg[7:0] <= bus_req.wdata;
      end else if (bus_req.wr && bus_req.addr == `RVS_OFF_EN_HI) begin
         irq_en_reg[12:8] <= bus_req.wdata[4:0];
      end
   end
   // Request flags; a new request wins over a vectoring or software clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pend_reg <= 13'h0000;
      end else if (in_reset) begin
         pend_reg <= 13'h0000; // RL12
      end else begin
         pend_reg <= (pend_reg
            & ~(take_now ? (13'h0001 << win_idx) : 13'h0000) // RL22
            & ~((bus_req.wr && bus_req.addr == `RVS_OFF_PEND_LO)
               ? {5'h00, bus_req.wdata} : 13'h0000)
            & ~((bus_req.wr && bus_req.addr == `RVS_OFF_PEND_HI)
               ? {bus_req.wdata[4:0], 8'h00} : 13'h0000))
            | irq_pulse; // RL7
      end
   end
   // Vector arbitration; reset address as soon as a reset is entered
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         take_reg <= 1'b0;
         vector_reg <= `RVS_VEC_RESET;
      end else begin
         take_reg <= take_now;
         if (state_next != RVS_ST_RUN && state_next != RVS_ST_SLEEP
            && state_next != RVS_ST_WAKE) begin
            vector_reg <= `RVS_VEC_RESET; // RL12 RL13
         end else if (take_now) begin
            vector_reg <= `RVS_VEC_FIRST + {8'h00, win_idx}; // RL9 RL10 RL11
         end
      end
   end
   // Register read port
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 8'h00;
      end else if (bus_req.rd) begin
         unique case (bus_req.addr)
            `RVS_OFF_STACK: rdata_reg <= stk_reg;
            `RVS_OFF_STATUS: rdata_reg <= {gie_reg, 7'h00};
            `RVS_OFF_CAUSE: rdata_reg <= {4'h0, cause_reg};
            `RVS_OFF_EN_LO: rdata_reg <= irq_en_reg[7:0];
            `RVS_OFF_EN_HI: rdata_reg <= {3'h0, irq_en_reg[12:8]};
            `RVS_OFF_PEND_LO: rdata_reg <= pend_reg[7:0];
            `RVS_OFF_PEND_HI: rdata_reg <= {3'h0, pend_reg[12:8]};
            default: rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end
   assign bus_rdata = rdata_reg;
   assign core_reset = core_reset_reg;
   assign core_halt = core_halt_reg;
   assign irq_take = take_reg;
   assign irq_vector = vector_reg;
   assign stack_top_pointer = stk_reg;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   sequence s_sleeping_wake;
      (state_reg == RVS_ST_SLEEP) && wake_req && !src_active;
   endsequence
   sequence s_clock_part;
      (state_reg == RVS_ST_WAKE)
         && (cnt_reg == ck_cycles($past(startup_delay_select)));
   endsequence

   stack_push_a: assert property ( // RL2
      stack_op.push_byte && !in_reset && !take_now && !stack_op.call_push
      |=> stk_reg == $past(stk_reg) - 8'h01)
      else $error("push did not lower stack by one");
   stack_call_a: assert property ( // RL3
      (take_now || stack_op.call_push) && !in_reset
      |=> stk_reg == $past(stk_reg) - 8'h02)
      else $error("call or entry did not lower stack by two");
   stack_pop_a: assert property ( // RL4
      stack_op.pop_byte && !in_reset && !take_now && !stack_op.call_push
      && !stack_op.push_byte |=> stk_reg == $past(stk_reg) + 8'h01)
      else $error("pop did not raise stack by one");
   stack_exit_a: assert property ( // RL5
      stack_op.irq_exit && !in_reset && !take_now && !stack_op.call_push
      && !stack_op.push_byte && !stack_op.pop_byte
      |=> stk_reg == $past(stk_reg) + 8'h02 && gie_reg)
      else $error("exit did not raise stack by two");
   take_gate_a: assert property ( // RL8
      irq_take |-> $past(gie_reg) && $past(|live) && !gie_reg)
      else $error("interrupt taken without enables");
   vector_prio_a: assert property ( // RL9
      irq_take |-> irq_vector == `RVS_VEC_FIRST + {8'h00, $past(win_idx)}
      && (!pend_reg[$past(win_idx)] || $past(irq_pulse[win_idx])))
      else $error("wrong vector or flag not cleared");
   wdt_pulse_a: assert property ( // RL20
      wdt_pulse_reg |=> !wdt_pulse_reg ##0 state_reg == RVS_ST_HOLD)
      else $error("watchdog pulse longer than one clock");
   wdt_cause_a: assert property ( // RL14
      $rose(wdt_pulse_reg) |-> $past(wdt_enable && wdt_timeout))
      else $error("watchdog reset without timeout");
   hold_reset_a: assert property ( // RL23
      src_active |=> core_reset && state_reg == RVS_ST_HOLD)
      else $error("core released while reset source active");
   wake_skip_a: assert property ( // RL17
      s_sleeping_wake |=> s_clock_part ##0 !core_reset)
      else $error("wake did not load clock count only");
   reset_vector_a: assert property ( // RL12
      core_reset |-> irq_vector == `RVS_VEC_RESET && !take_reg)
      else $error("vector not at reset address during reset");

endmodule : rvs_reset_vector_ctrl

// ### verification/rvs_core_model.sv
// Core stand-in: watchdog oscillator ticks and instruction boundaries
`timescale 1ns/10ps
module rvs_core_model (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Control
   input wire logic bnd_en,
   // Pulses to the block
   output logic wdt_osc_tick,
   output logic instr_boundary
);
   logic [1:0] phase_reg;

   // Oscillator ticks every other clock, boundaries every third
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= 2'h0;
         wdt_osc_tick <= 1'b0;
         instr_boundary <= 1'b0;
      end else begin
         phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
         wdt_osc_tick <= ~wdt_osc_tick;
         instr_boundary <= bnd_en && (phase_reg == 2'h0);
      end
   end
endmodule : rvs_core_model

// ### verification/reset_vector_startup_control_tb.sv
// Self-checking testbench for the reset, vector and stack control block
`timescale 1ns/10ps
module reset_vector_startup_control_tb;
   import rvs_pkg::*;
   logic clock, rst_n, por_req, ext_reset_req, bod_req, wdt_enable;
   logic wdt_timeout, wdt_osc_tick, sleep_req, wake_req, instr_boundary;
   logic bnd_en, core_reset, core_halt, irq_take, rd_pend;
   logic [2:0] startup_delay_select;
   logic [12:0] irq_pulse;
   logic [12:0] m;
   logic [7:0] bus_rdata, stack_top_pointer, sp_exp;
   logic [11:0] irq_vector;
   rvs_stack_op_t stack_op;
   rvs_bus_req_t bus_req;
   int err_count, n_tests, cyc, n, k;
   logic [7:0] rq[$];
   logic [11:0] iq[$];
   int rt_t[8] = '{4096, 0, 8, 4096, 0, 8, 4096, 0};
   int ck_t[8] = '{6, 6, 8, 8, 8, 1024, 1024, 1024};
   logic [4:0] ops[5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
   int dl[5] = '{-1, 1, -2, 2, 2};

   rvs_reset_vector_ctrl #(.P_RT_LONG(17'h00008), .P_CK_16K(17'h00008)) dut (
      .clock(clock), .rst_n(rst_n), .por_req(por_req),
      .ext_reset_req(ext_reset_req), .bod_req(bod_req),
      .wdt_enable(wdt_enable), .wdt_timeout(wdt_timeout),
      .wdt_osc_tick(wdt_osc_tick),
      .startup_delay_select(startup_delay_select),
      .sleep_req(sleep_req), .wake_req(wake_req),
      .instr_boundary(instr_boundary), .stack_op(stack_op),
      .irq_pulse(irq_pulse), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .core_reset(core_reset), .core_halt(core_halt), .irq_take(irq_take),
      .irq_vector(irq_vector), .stack_top_pointer(stack_top_pointer));

   rvs_core_model partner (.clock(clock), .rst_n(rst_n), .bnd_en(bnd_en),
      .wdt_osc_tick(wdt_osc_tick), .instr_boundary(instr_boundary));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic chk(input string name, input logic [15:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize

   task automatic bus(input logic [5:0] a, input logic [7:0] d,
                      input logic w);
      @(posedge clock);
      bus_req <= '{a, d, w, !w};
      @(posedge clock);
      bus_req <= '{a, 8'h00, 1'b0, 1'b0};
   endtask : bus

   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      rq.push_back(e);
      bus(a, 8'h00, 1'b0);
   endtask : rd

   task automatic op(input logic [4:0] o, input int delta);
      @(posedge clock);
      stack_op <= o;
      @(posedge clock);
      stack_op <= '0;
      sp_exp = sp_exp + 8'(delta);
   endtask : op

   // Counts cycles while a level stays high, bounded
   task automatic hold_len(input logic halt, output int len);
      len = 0;
      while ((halt ? core_halt : core_reset) === 1'b1 && len < 20000) begin
         @(posedge clock);
         len++;
      end
   endtask : hold_len

   // One reset from a chosen source, then the start-up delay is timed
   task automatic boot(input int sel, input int src);
      int e;
      bus(6'h34, 8'h00, 1'b1);
      @(posedge clock);
      startup_delay_select <= 3'(sel);
      por_req <= (src == 0);
      ext_reset_req <= (src == 1);
      bod_req <= (src == 2);
      wdt_enable <= (src == 3);
      wdt_timeout <= (src == 3);
      @(posedge clock);
      {por_req, ext_reset_req, bod_req, wdt_timeout, wdt_enable} <= '0;
      repeat (2) @(posedge clock);
      chk("core_reset", core_reset, 1'b1);
      chk("irq_vector", irq_vector, 12'h000);
      e = 2 * rt_t[sel] + ck_t[sel];
      hold_len(1'b0, n);
      chk("delay_len", (n + 5 >= e) && (n <= e + 5), 1'b1);
      rd(6'h34, 8'h01 << src);
      rd(6'h3D, 8'h00);
      $display("test boot %0d done, %0d cycles", sel, n);
   endtask : boot

   // Read data and taken vectors are matched against the oldest note
   always @(posedge clock) begin
      if (rd_pend === 1'b1 && rq.size() > 0)
         chk("bus_rdata", bus_rdata, rq.pop_front());
      rd_pend <= bus_req.rd;
      if (irq_take === 1'b1) begin
         if (iq.size() > 0) chk("irq_vector", irq_vector, iq.pop_front());
         else chk("irq_take", irq_take, 1'b0);
      end
   end

   always @(posedge clock) begin
      cyc++;
      if (cyc == 80000) begin
         err_count++;
         summarize();
      end
   end

   initial begin
      void'($urandom(32'h5718e6da));
      {rst_n, por_req, ext_reset_req, bod_req, wdt_enable} = '0;
      {wdt_timeout, sleep_req, wake_req, rd_pend} = '0;
      bnd_en = 1'b1;
      startup_delay_select = 3'b001;
      stack_op = '0;
      irq_pulse = '0;
      bus_req = '0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      hold_len(1'b0, n);
      for (int s = 0; s < 8; s++) boot(s, s % 4);
      // Timeout without the watchdog enabled must not reset
      @(posedge clock);
      wdt_timeout <= 1'b1;
      @(posedge clock);
      wdt_timeout <= 1'b0;
      repeat (6) @(posedge clock);
      chk("core_reset", core_reset, 1'b0);
      $display("test watchdog done");
      // Wake from sleep counts the clock part only
      @(posedge clock);
      startup_delay_select <= 3'b011;
      sleep_req <= 1'b1;
      @(posedge clock);
      sleep_req <= 1'b0;
      repeat (2) @(posedge clock);
      chk("core_halt", core_halt, 1'b1);
      wake_req <= 1'b1;
      @(posedge clock);
      wake_req <= 1'b0;
      hold_len(1'b1, n);
      chk("wake_len", (n + 5 >= 8) && (n <= 12), 1'b1);
      $display("test sleep done");
      sp_exp = 8'h62 + 8'($urandom_range(0, 120));
      bus(6'h3D, sp_exp, 1'b1);
      rd(6'h3D, sp_exp);
      rd(6'h10, 8'h00);
      for (int i = 0; i < 5; i++) begin
         op(ops[i], dl[i]);
         rd(6'h3D, sp_exp);
         chk("stack_top_pointer", stack_top_pointer, sp_exp);
      end
      $display("test stack done");
      bus(6'h36, 8'h00, 1'b1);
      bus(6'h37, 8'h00, 1'b1);
      bus(6'h3F, 8'h80, 1'b1);
      @(posedge clock);
      irq_pulse <= 13'h0004;
      @(posedge clock);
      irq_pulse <= '0;
      repeat (10) @(posedge clock);
      rd(6'h20, 8'h04);
      iq.push_back(12'h003);
      bus(6'h36, 8'h04, 1'b1);
      n = 0;
      while (iq.size() > 0 && n < 30) begin
         @(posedge clock);
         n++;
      end
      sp_exp = sp_exp - 8'h02;
      rd(6'h3D, sp_exp);
      op(5'h01, 2);
      bus(6'h36, 8'hFF, 1'b1);
      bus(6'h37, 8'h1F, 1'b1);
      for (int i = 0; i < 13; i++) begin
         iq.push_back(12'(i + 1));
         @(posedge clock);
         irq_pulse <= 13'(1 << i);
         @(posedge clock);
         irq_pulse <= '0;
         n = 0;
         while (iq.size() > 0 && n < 30) begin
            @(posedge clock);
            n++;
         end
         op(5'h01, 0);
      end
      $display("test vectors done");
      for (int r = 0; r < 2; r++) begin
         bus(6'h3F, 8'h00, 1'b1);
         m = 13'($urandom);
         if (m == '0) m = 13'h1001;
         @(posedge clock);
         irq_pulse <= m;
         @(posedge clock);
         irq_pulse <= '0;
         rd(6'h20, m[7:0]);
         rd(6'h22, {3'h0, m[12:8]});
         for (int i = 0; i < 13; i++) if (m[i]) iq.push_back(12'(i + 1));
         bus(6'h3F, 8'h80, 1'b1);
         k = iq.size();
         n = 0;
         while (iq.size() > 0 && n < 600) begin
            @(posedge clock);
            n++;
            if (iq.size() < k) begin
               k = iq.size();
               repeat (8) @(posedge clock);
               chk("one_take", 16'(iq.size()), 16'(k));
               op(5'h01, 0);
            end
         end
         chk("all_taken", 16'(iq.size()), 16'h0000);
         rd(6'h20, 8'h00);
         rd(6'h22, 8'h00);
         rd(6'h3D, sp_exp);
      end
      $display("test priority done");
      // Pin reset after vectors were taken must return to the reset vector
      boot(1, 1);
      repeat (4) @(posedge clock);
      summarize();
   end
endmodule : reset_vector_startup_control_tb
